// *** rtl/mio_consts.svh ***
// constants of the multiplexed i/o block: register indices, field positions, reset values
// assumes a 32-bit apb slave where each register index sits at byte address index*4
`ifndef MIO_CONSTS_SVH
`define MIO_CONSTS_SVH

// register indices
`define MIO_IDX_P4_DATA   6'h0C
`define MIO_IDX_P5_DATA   6'h0D
`define MIO_IDX_P4_DIR    6'h0E
`define MIO_IDX_P4_FSEL   6'h0F
`define MIO_IDX_P6_DATA   6'h12
`define MIO_IDX_P7_DATA   6'h13
`define MIO_IDX_P6_DIR    6'h14
`define MIO_IDX_P6_FSEL   6'h15
`define MIO_IDX_P7_DIR    6'h16
`define MIO_IDX_P7_FSEL   6'h17
`define MIO_IDX_ODE       6'h2F

// reset values
`define MIO_RST_P4_LATCH  3'h7
`define MIO_RST_P6_LATCH  4'hF
`define MIO_RST_P7_LATCH  5'h1F
`define MIO_RST_ODE       4'h0

// open-drain select field positions
`define MIO_ODE_TXD0      0
`define MIO_ODE_TXD1      1
`define MIO_ODE_P61       2
`define MIO_ODE_P62       3

// port 6 pin roles
`define MIO_P6_SCK        0
`define MIO_P6_SDA        1
`define MIO_P6_SCL        2
`define MIO_P6_INT        3

// port 7 pin roles
`define MIO_P7_T0IN       0
`define MIO_P7_T4IN       3

// port 5 converter trigger pin
`define MIO_P5_TRIG       3

`endif

// *** rtl/mio_pkg.sv ***
// types shared by the multiplexed i/o block
// assumes mio_consts.svh for all numeric constants
package mio_pkg;

    // drive bundle of one port; bit n belongs to pin n, unused bits stay 0
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] enable;
    } mio_drive_t;

endpackage

// *** rtl/mio_ports.sv ***
// multiplexed i/o ports 4, 5, 6 and 7 with apb register access
// assumes synchronous pin inputs, a pad ring that resolves level/enable, and
// peripheral units (select decoder, serial bus, timers, interrupt) outside
`timescale 1ns/1ps
`include "mio_consts.svh"

module mio_ports #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               resetn_i,
    // apb slave
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [ADDR_W-1:0]  paddr_i,
    input  wire logic [31:0]        pwdata_i,
    output logic      [31:0]        prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    // port 4
    input  wire logic [2:0]         p4_pin_i,
    input  wire logic [2:0]         select_space_n_i,
    output mio_pkg::mio_drive_t     p4_drive_o,
    output logic      [2:0]         p4_pullup_en_o,
    // port 5
    input  wire logic [3:0]         p5_pin_i,
    output logic                    adc_trigger_o,
    // port 6
    input  wire logic [3:0]         p6_pin_i,
    input  wire logic [2:0]         sbi_out_i,
    input  wire logic [2:0]         sbi_oe_i,
    output mio_pkg::mio_drive_t     p6_drive_o,
    output logic      [2:0]         sbi_pin_o,
    output logic                    external_interrupt_zero_o,
    output logic      [1:0]         txd_open_drain_o,
    // port 7
    input  wire logic [4:0]         p7_pin_i,
    input  wire logic [2:0]         timer_out_i,
    output mio_pkg::mio_drive_t     p7_drive_o,
    output logic                    timer0_clock_in_o,
    output logic                    timer4_clock_in_o
);

    // the index decode needs byte address bits 7:2
    if (ADDR_W < 8)
    begin : g_bad_addr_w
        $error("ADDR_W must be at least 8");
    end

    // registers
    logic [2:0]  port4_data_latch_r;
    logic [2:0]  port4_direction_r;
    logic [2:0]  port4_function_select_r;
    logic [3:0]  port6_data_latch_r;
    logic [3:0]  port6_direction_r;
    logic [3:0]  port6_function_select_r;
    logic [4:0]  port7_data_latch_r;
    logic [4:0]  port7_direction_r;
    logic [4:0]  port7_function_select_r;
    logic [3:0]  open_drain_select_r;

    // bus decode
    logic [5:0]  idx;
    logic        aligned;
    logic        setup;
    logic        wr_en;
    logic        hit;
    logic [31:0] rd_nxt;
    logic [7:0]  wb;

    assign idx     = paddr_i[7:2];
    assign aligned = (paddr_i[1:0] == 2'h0) && ((paddr_i >> 8) == '0);
    assign setup   = psel_i && !penable_i;
    // the write lands at the single access edge where pready is high
    assign wr_en   = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
    assign wb      = pwdata_i[7:0];

    always_comb
    begin
        hit = aligned;
        case (idx)
            `MIO_IDX_P4_DATA,
            `MIO_IDX_P5_DATA,
            `MIO_IDX_P4_DIR,
            `MIO_IDX_P4_FSEL,
            `MIO_IDX_P6_DATA,
            `MIO_IDX_P7_DATA,
            `MIO_IDX_P6_DIR,
            `MIO_IDX_P6_FSEL,
            `MIO_IDX_P7_DIR,
            `MIO_IDX_P7_FSEL,
            `MIO_IDX_ODE:
            begin
                hit = aligned;
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase
    end

    // read mux; write-only and unused bits read zero
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        if (hit)
        begin
            case (idx)
                `MIO_IDX_P4_DATA:
                begin
                    rd_nxt[2:0] = p4_pin_i;
                end
                `MIO_IDX_P5_DATA:
                begin
                    rd_nxt[3:0] = p5_pin_i;
                end
                `MIO_IDX_P6_DATA:
                begin
                    rd_nxt[3:0] = p6_pin_i;
                end
                `MIO_IDX_P7_DATA:
                begin
                    rd_nxt[4:0] = p7_pin_i;
                end
                `MIO_IDX_ODE:
                begin
                    rd_nxt[3:0] = open_drain_select_r;
                end
                default:
                begin
                    rd_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    // zero-wait slave: answer in the cycle after setup
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end
        else
        begin
            pready_o  <= setup;
            pslverr_o <= setup && !hit;
            if (setup && !pwrite_i)
            begin
                prdata_o <= rd_nxt;
            end
        end
    end

    // port 4 registers
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            port4_data_latch_r      <= `MIO_RST_P4_LATCH;
            port4_direction_r       <= 3'h0;
            port4_function_select_r <= 3'h0;
        end
        else if (wr_en)
        begin
            case (idx)
                `MIO_IDX_P4_DATA:
                begin
                    port4_data_latch_r <= wb[2:0];
                end
                `MIO_IDX_P4_DIR:
                begin
                    port4_direction_r <= wb[2:0];
                end
                `MIO_IDX_P4_FSEL:
                begin
                    port4_function_select_r <= wb[2:0];
                end
                default:
                begin
                    port4_data_latch_r <= port4_data_latch_r;
                end
            endcase
        end
    end

    // port 6 registers
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            port6_data_latch_r      <= `MIO_RST_P6_LATCH;
            port6_direction_r       <= 4'h0;
            port6_function_select_r <= 4'h0;
        end
        else if (wr_en)
        begin
            case (idx)
                `MIO_IDX_P6_DATA:
                begin
                    port6_data_latch_r <= wb[3:0];
                end
                `MIO_IDX_P6_DIR:
                begin
                    port6_direction_r <= wb[3:0];
                end
                `MIO_IDX_P6_FSEL:
                begin
                    port6_function_select_r <= wb[3:0];
                end
                default:
                begin
                    port6_data_latch_r <= port6_data_latch_r;
                end
            endcase
        end
    end

    // port 7 registers
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            port7_data_latch_r      <= `MIO_RST_P7_LATCH;
            port7_direction_r       <= 5'h00;
            port7_function_select_r <= 5'h00;
        end
        else if (wr_en)
        begin
            case (idx)
                `MIO_IDX_P7_DATA:
                begin
                    port7_data_latch_r <= wb[4:0];
                end
                `MIO_IDX_P7_DIR:
                begin
                    port7_direction_r <= wb[4:0];
                end
                `MIO_IDX_P7_FSEL:
                begin
                    port7_function_select_r <= wb[4:0];
                end
                default:
                begin
                    port7_data_latch_r <= port7_data_latch_r;
                end
            endcase
        end
    end

    // open-drain selection
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            open_drain_select_r <= `MIO_RST_ODE;
        end
        else if (wr_en && (idx == `MIO_IDX_ODE))
        begin
            open_drain_select_r <= wb[3:0];
        end
    end

    // port 4 pin steering
    logic [2:0] p4_lvl_nxt;
    logic [2:0] p4_en_nxt;
    logic [2:0] p4_pu_nxt;

    always_comb
    begin
        for (int b = 0; b < 3; b++)
        begin
            // select mode only once both bits are set; order of setting is software's job
            p4_lvl_nxt[b] = (port4_function_select_r[b] && port4_direction_r[b])
                          ? select_space_n_i[b]
                          : port4_data_latch_r[b];
            p4_en_nxt[b]  = port4_direction_r[b];
            p4_pu_nxt[b]  = !port4_direction_r[b] && port4_data_latch_r[b];
        end
    end

    // port 6 pin steering
    logic [3:0] p6_val;
    logic [3:0] p6_req;
    logic [3:0] p6_lvl_nxt;
    logic [3:0] p6_en_nxt;
    logic [3:0] p6_od;

    assign p6_od = {1'b0, open_drain_select_r[`MIO_ODE_P62],
                    open_drain_select_r[`MIO_ODE_P61], 1'b0};

    always_comb
    begin
        for (int b = 0; b < 4; b++)
        begin
            p6_val[b] = port6_data_latch_r[b];
            p6_req[b] = port6_direction_r[b];
        end
        for (int b = 0; b < 3; b++)
        begin
            if (port6_function_select_r[b])
            begin
                // serial unit owns the value on its three pins; its drive request is gated by the direction bit
                p6_val[b] = sbi_out_i[b];
                p6_req[b] = port6_direction_r[b] && sbi_oe_i[b];
            end
        end
        for (int b = 0; b < 4; b++)
        begin
            if (p6_od[b])
            begin
                // open drain only pulls low; high is left to the bus pull-up
                p6_lvl_nxt[b] = 1'b0;
                p6_en_nxt[b]  = p6_req[b] && !p6_val[b];
            end
            else
            begin
                p6_lvl_nxt[b] = p6_val[b];
                p6_en_nxt[b]  = p6_req[b];
            end
        end
    end

    // port 7 pin steering
    logic [4:0] p7_lvl_nxt;
    logic [4:0] p7_en_nxt;
    logic [4:0] p7_alt;

    assign p7_alt = {timer_out_i[2], 1'b0, timer_out_i[1], timer_out_i[0], 1'b0};

    always_comb
    begin
        for (int b = 0; b < 5; b++)
        begin
            p7_en_nxt[b]  = port7_direction_r[b];
            p7_lvl_nxt[b] = port7_data_latch_r[b];
            if ((b != `MIO_P7_T0IN) && (b != `MIO_P7_T4IN) && port7_function_select_r[b]
                && port7_direction_r[b])
            begin
                p7_lvl_nxt[b] = p7_alt[b];
            end
        end
    end

    // registered pin drive; one cycle from register or peripheral change to pad
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            p4_drive_o     <= '0;
            p6_drive_o     <= '0;
            p7_drive_o     <= '0;
            p4_pullup_en_o <= `MIO_RST_P4_LATCH;
        end
        else
        begin
            p4_drive_o.level  <= {5'h00, p4_lvl_nxt};
            p4_drive_o.enable <= {5'h00, p4_en_nxt};
            p6_drive_o.level  <= {4'h0, p6_lvl_nxt};
            p6_drive_o.enable <= {4'h0, p6_en_nxt};
            p7_drive_o.level  <= {3'h0, p7_lvl_nxt};
            p7_drive_o.enable <= {3'h0, p7_en_nxt};
            p4_pullup_en_o    <= p4_pu_nxt;
        end
    end

    // pin levels and open-drain selects handed to peripherals
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sbi_pin_o                 <= 3'h7;
            external_interrupt_zero_o <= 1'b0;
            adc_trigger_o             <= 1'b0;
            timer0_clock_in_o         <= 1'b0;
            timer4_clock_in_o         <= 1'b0;
            txd_open_drain_o          <= 2'h0;
        end
        else
        begin
            // unselected serial lines present idle high
            sbi_pin_o <= p6_pin_i[2:0] | ~port6_function_select_r[2:0];
            external_interrupt_zero_o <= port6_function_select_r[`MIO_P6_INT]
                                      && !port6_direction_r[`MIO_P6_INT]
                                      && p6_pin_i[`MIO_P6_INT];
            adc_trigger_o     <= p5_pin_i[`MIO_P5_TRIG];
            timer0_clock_in_o <= p7_pin_i[`MIO_P7_T0IN];
            timer4_clock_in_o <= p7_pin_i[`MIO_P7_T4IN];
            txd_open_drain_o  <= {open_drain_select_r[`MIO_ODE_TXD1],
                                  open_drain_select_r[`MIO_ODE_TXD0]};
        end
    end

endmodule // mio_ports

// *** sim/mio_pad_model.sv ***
// pad ring and far-side drivers of one port: resolves each pin level
// assumes registered drive bundles from the block; ext_* come from the bench
`timescale 1ns/1ps
module mio_pad_model #(
    parameter int W = 3
) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] dut_en_i,
    input  wire logic [W-1:0] dut_lvl_i,
    input  wire logic [W-1:0] pull_i,
    input  wire logic [W-1:0] ext_en_i,
    input  wire logic [W-1:0] ext_lvl_i,
    output logic      [W-1:0] pin_o
);
    // floating lines toggle so a stale value is never mistaken for a level
    logic tgl_r = 1'b0;
    always_ff @(posedge clk_i)
    begin
        tgl_r <= ~tgl_r;
    end
    // both sides driving resolve as wired-and
    always_comb
    begin
        pin_o = (dut_en_i & dut_lvl_i & (~ext_en_i | ext_lvl_i))
              | (~dut_en_i & ext_en_i & ext_lvl_i)
              | (~dut_en_i & ~ext_en_i & (pull_i | {W{tgl_r}}));
    end
endmodule // mio_pad_model

// *** sim/mio_ports_sva.sv ***
// concurrent checks on the multiplexed i/o ports, bound into mio_ports
// assumes one clock domain and registered outputs with one cycle latency
`timescale 1ns/1ps
module mio_ports_sva #(
    parameter int ADDR_W = 8
) (
    input wire logic                ref_clk_i,
    input wire logic                resetn_i,
    input wire logic                psel_i,
    input wire logic                penable_i,
    input wire logic                pwrite_i,
    input wire logic [ADDR_W-1:0]   paddr_i,
    input wire logic [31:0]         prdata_o,
    input wire logic                pready_o,
    input wire logic                pslverr_o,
    input mio_pkg::mio_drive_t      p4_drive_o,
    input wire logic [2:0]          p4_pullup_en_o,
    input wire logic [3:0]          p5_pin_i,
    input wire logic                adc_trigger_o,
    input wire logic [3:0]          p6_pin_i,
    input mio_pkg::mio_drive_t      p6_drive_o,
    input wire logic [2:0]          sbi_pin_o,
    input wire logic                external_interrupt_zero_o,
    input wire logic [4:0]          p7_pin_i,
    input mio_pkg::mio_drive_t      p7_drive_o,
    input wire logic                timer0_clock_in_o,
    input wire logic                timer4_clock_in_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    AST_ANSWER: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no answer one cycle after setup");
    AST_ONE_PULSE: assert property (pready_o |=> !pready_o)
        else $error("ready held past the access cycle");
    AST_REFUSE: assert property (
        psel_i && !penable_i && paddr_i[1:0] != 2'b00 |=> pslverr_o)
        else $error("misaligned access not refused");
    AST_ERR_DATA: assert property (
        pslverr_o && !pwrite_i |-> pready_o && prdata_o == 32'h0000_0000)
        else $error("refused read returned data");
    AST_EXTERNAL_INTERRUPT_ZERO: assert property (
        external_interrupt_zero_o |-> $past(p6_pin_i[3]))
        else $error("interrupt line high without pin high");
    AST_TMR_CLK: assert property ($past(resetn_i) |->
        timer0_clock_in_o == $past(p7_pin_i[0]) && timer4_clock_in_o == $past(p7_pin_i[3]))
        else $error("timer clock input does not follow pin");
    AST_TRIG: assert property (
        $past(resetn_i) |-> adc_trigger_o == $past(p5_pin_i[3]))
        else $error("converter trigger does not follow pin");
    AST_SBI: assert property (
        $past(resetn_i) |-> (~sbi_pin_o & $past(p6_pin_i[2:0])) == 3'h0)
        else $error("serial pin low while pad high");
    AST_UNUSED: assert property (p4_drive_o.enable[7:3] == 5'h00
        && p6_drive_o.enable[7:4] == 4'h0 && p7_drive_o.enable[7:5] == 3'h0)
        else $error("unused pin enable set");
    AST_RST_VAL: assert property ($rose(resetn_i) |->
        p4_pullup_en_o == 3'h7 && sbi_pin_o == 3'h7 && p4_drive_o.enable == 8'h00
        && p6_drive_o.enable == 8'h00 && p7_drive_o.enable == 8'h00)
        else $error("outputs wrong after reset");

    COV_ERR: cover property (pslverr_o);
    COV_EXTERNAL_INTERRUPT_ZERO: cover property (external_interrupt_zero_o);
    COV_WRITE: cover property (pready_o && pwrite_i);
endmodule // mio_ports_sva

bind mio_ports mio_ports_sva #(.ADDR_W(ADDR_W)) u_sva (.ref_clk_i, .resetn_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .p4_drive_o,
    .p4_pullup_en_o, .p5_pin_i, .adc_trigger_o, .p6_pin_i, .p6_drive_o, .sbi_pin_o,
    .external_interrupt_zero_o, .p7_pin_i, .p7_drive_o, .timer0_clock_in_o,
    .timer4_clock_in_o);

// *** sim/testbench.sv ***
// self-checking bench for mio_ports: apb master, pad models, scenarios
// assumes the zero-wait apb slave and one-cycle pin latency of the block
`timescale 1ns/1ps
`include "mio_consts.svh"
module testbench;
    logic                ref_clk_i = 1'b0;
    logic                resetn_i = 1'b0;
    logic                psel_i = 1'b0;
    logic                penable_i = 1'b0;
    logic                pwrite_i = 1'b0;
    logic [7:0]          paddr_i = 8'h00;
    logic [31:0]         pwdata_i = 32'h0000_0000;
    logic [2:0]          select_space_n_i = 3'h7;
    logic [3:0]          p5_pin_i = 4'h0;
    logic [2:0]          sbi_out_i = 3'h0;
    logic [2:0]          sbi_oe_i = 3'h0;
    logic [2:0]          timer_out_i = 3'h0;
    logic [2:0]          e4 = 3'h0;
    logic [2:0]          v4 = 3'h0;
    logic [3:0]          e6 = 4'h0;
    logic [3:0]          v6 = 4'h0;
    logic [4:0]          e7 = 5'h00;
    logic [4:0]          v7 = 5'h00;
    logic [31:0]         prdata_o;
    logic                pready_o;
    logic                pslverr_o;
    logic [2:0]          p4_pin_i;
    logic [3:0]          p6_pin_i;
    logic [4:0]          p7_pin_i;
    mio_pkg::mio_drive_t p4_drive_o;
    mio_pkg::mio_drive_t p6_drive_o;
    mio_pkg::mio_drive_t p7_drive_o;
    logic [2:0]          p4_pullup_en_o;
    logic                adc_trigger_o;
    logic [2:0]          sbi_pin_o;
    logic                external_interrupt_zero_o;
    logic [1:0]          txd_open_drain_o;
    logic                timer0_clock_in_o;
    logic                timer4_clock_in_o;
    logic [31:0]         q;
    logic                e;
    int                  error_cnt = 0;
    int                  n_compared = 0;

    always #2 ref_clk_i = ~ref_clk_i;

    mio_ports dut (.*);
    mio_pad_model #(.W(3)) u_pad4 (.clk_i(ref_clk_i), .dut_en_i(p4_drive_o.enable[2:0]),
        .dut_lvl_i(p4_drive_o.level[2:0]), .pull_i(p4_pullup_en_o), .ext_en_i(e4),
        .ext_lvl_i(v4), .pin_o(p4_pin_i));
    // two-wire lines carry board pull-ups
    mio_pad_model #(.W(4)) u_pad6 (.clk_i(ref_clk_i), .dut_en_i(p6_drive_o.enable[3:0]),
        .dut_lvl_i(p6_drive_o.level[3:0]), .pull_i(4'h6), .ext_en_i(e6),
        .ext_lvl_i(v6), .pin_o(p6_pin_i));
    mio_pad_model #(.W(5)) u_pad7 (.clk_i(ref_clk_i), .dut_en_i(p7_drive_o.enable[4:0]),
        .dut_lvl_i(p7_drive_o.level[4:0]), .pull_i(5'h00), .ext_en_i(e7),
        .ext_lvl_i(v7), .pin_o(p7_pin_i));

    function automatic logic [7:0] ad(input logic [5:0] i);
        return {i, 2'b00};
    endfunction

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, x, g);
        end
    endtask

    // holds the request until ready is sampled high at a rising edge; only the
    // watchdog ends a wait that never gets its answer
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= {24'h00_0000, d};
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge ref_clk_i);
        end
        while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic settle;
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        settle();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
        bus(1'b0, a, 8'h00);
        chk(nm, x, q);
    endtask

    task automatic t_reset;
        @(negedge ref_clk_i);
        chk("p4 pull", 32'h0000_0007, 32'(p4_pullup_en_o));
        chk("p4 drive", 32'h0000_0000, 32'(p4_drive_o.enable));
        chk("p6 drive", 32'h0000_0000, 32'(p6_drive_o.enable));
        chk("p7 drive", 32'h0000_0000, 32'(p7_drive_o.enable));
        chk("txd od", 32'h0000_0000, 32'(txd_open_drain_o));
        rd(ad(`MIO_IDX_ODE), 32'h0000_0000, "ode");
    endtask

    task automatic t_port4;
        wr(ad(`MIO_IDX_P4_DIR), 8'h07);
        chk("p4 drive", 32'h0000_0707, 32'(p4_drive_o));
        wr(ad(`MIO_IDX_P4_DATA), 8'h02);
        chk("p4 drive", 32'h0000_0207, 32'(p4_drive_o));
        wr(ad(`MIO_IDX_P4_DIR), 8'h00);
        chk("p4 pull", 32'h0000_0002, 32'(p4_pullup_en_o));
        chk("p4 enable", 32'h0000_0000, 32'(p4_drive_o.enable));
        @(posedge ref_clk_i);
        e4 <= 3'h5;
        v4 <= 3'h1;
        rd(ad(`MIO_IDX_P4_DATA), 32'h0000_0003, "p4 in pins");
        e4 <= 3'h0;
        @(posedge ref_clk_i);
        select_space_n_i <= 3'h4;
        wr(ad(`MIO_IDX_P4_FSEL), 8'h03);
        wr(ad(`MIO_IDX_P4_DIR), 8'h07);
        chk("p4 select", 32'h0000_0007, 32'(p4_drive_o));
        @(posedge ref_clk_i);
        select_space_n_i <= 3'h3;
        settle();
        chk("p4 select", 32'h0000_0307, 32'(p4_drive_o));
        rd(ad(`MIO_IDX_P4_DATA), 32'h0000_0003, "p4 pins");
    endtask

    task automatic t_port6;
        wr(ad(`MIO_IDX_P6_DIR), 8'h0F);
        chk("p6 drive", 32'h0000_0F0F, 32'(p6_drive_o));
        wr(ad(`MIO_IDX_P6_DATA), 8'h03);
        chk("p6 drive", 32'h0000_030F, 32'(p6_drive_o));
        rd(ad(`MIO_IDX_P6_DATA), 32'h0000_0003, "p6 pins");
        wr(ad(`MIO_IDX_P6_DIR), 8'h07);
        @(posedge ref_clk_i);
        e6 <= 4'h8;
        v6 <= 4'h8;
        sbi_oe_i <= 3'h3;
        sbi_out_i <= 3'h2;
        wr(ad(`MIO_IDX_P6_FSEL), 8'h0F);
        chk("external_interrupt_zero", 32'h0000_0001, 32'(external_interrupt_zero_o));
        chk("p6 serial", 32'h0000_0203, 32'(p6_drive_o));
        chk("sbi pins", 32'h0000_0006, 32'(sbi_pin_o));
        rd(ad(`MIO_IDX_P6_DATA), 32'h0000_000E, "p6 pins");
        wr(ad(`MIO_IDX_ODE), 8'h07);
        chk("p6 od", 32'h0000_0001, 32'(p6_drive_o));
        chk("txd od", 32'h0000_0003, 32'(txd_open_drain_o));
        rd(ad(`MIO_IDX_ODE), 32'h0000_0007, "ode");
        wr(ad(`MIO_IDX_P6_DIR), 8'h0F);
        chk("external_interrupt_zero", 32'h0000_0000, 32'(external_interrupt_zero_o));
    endtask

    task automatic t_port7;
        @(posedge ref_clk_i);
        timer_out_i <= 3'h5;
        wr(ad(`MIO_IDX_P7_FSEL), 8'h16);
        wr(ad(`MIO_IDX_P7_DIR), 8'h1F);
        chk("p7 timer", 32'h0000_1B1F, 32'(p7_drive_o));
        wr(ad(`MIO_IDX_P7_DIR), 8'h00);
        @(posedge ref_clk_i);
        e7 <= 5'h1F;
        v7 <= 5'h09;
        settle();
        chk("tmr clk", 32'h0000_0003, 32'({timer4_clock_in_o, timer0_clock_in_o}));
        rd(ad(`MIO_IDX_P7_DATA), 32'h0000_0009, "p7 pins");
        rd(ad(`MIO_IDX_P7_DIR), 32'h0000_0000, "p7 dir");
        bus(1'b0, 8'hFC, 8'h00);
        chk("unmapped err", 32'h0000_0001, 32'(e));
        chk("unmapped data", 32'h0000_0000, q);
        bus(1'b1, 8'h31, 8'hFF);
        chk("misaligned err", 32'h0000_0001, 32'(e));
    endtask

    task automatic t_port5;
        @(posedge ref_clk_i);
        p5_pin_i <= 4'hA;
        rd(ad(`MIO_IDX_P5_DATA), 32'h0000_000A, "p5 pins");
        chk("adc trig", 32'h0000_0001, 32'(adc_trigger_o));
    endtask

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_port4();
        t_port6();
        t_port7();
        t_port5();
        wrap_up();
    end

    // whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge ref_clk_i);
        error_cnt++;
        wrap_up();
    end
endmodule // testbench
